// *** design/eia_params.svh ***
// Register map, field positions, reset values and vectors of the extended interrupt aggregator
`ifndef EIA_PARAMS_SVH
`define EIA_PARAMS_SVH
`define EIA_OFS_A_EN 8'h00
`define EIA_OFS_A_FLAGS 8'h04
`define EIA_OFS_A_CLR 8'h08
`define EIA_OFS_B_EN 8'h0c
`define EIA_OFS_B_FLAGS 8'h10
`define EIA_OFS_B_CLR 8'h14
`define EIA_OFS_D_EN 8'h18
`define EIA_OFS_D_FLAGS 8'h1c
`define EIA_OFS_D_CLR 8'h20
`define EIA_OFS_CORE_EN 8'h24
`define EIA_OFS_EXT_EN 8'h28
`define EIA_OFS_EXT_FLAGS 8'h2c
`define EIA_MASK_A 8'hbf
`define EIA_MASK_B 8'hec
`define EIA_MASK_D 8'h7f
`define EIA_MASK_CORE_EN 8'h80
`define EIA_MASK_EXT_EN 8'h0b
`define EIA_ONES_EXT_EN 8'he0
`define EIA_MASK_EXT_FLAGS 8'hb0
`define EIA_ONES_EXT_FLAGS 8'h08
`define EIA_BIT_GLOBAL_EN 7
`define EIA_BIT_EN_IRQ8 0
`define EIA_BIT_EN_IRQ9 1
`define EIA_BIT_EN_IRQ11 3
`define EIA_BIT_FLAG_IRQ8 4
`define EIA_BIT_FLAG_IRQ9 5
`define EIA_BIT_FLAG_IRQ11 7
`define EIA_VECTOR_IRQ8 8'h43
`define EIA_VECTOR_IRQ9 8'h4b
`define EIA_VECTOR_IRQ11 8'h5b
`define EIA_RST_REG 8'h00
`endif

// *** design/eia_pkg.sv ***
// Types shared by the extended interrupt aggregator
package eia_pkg;
	typedef logic [7:0] eia_reg_t;
	typedef enum logic [1:0]
	{
		EIA_RESP_OKAY = 2'b00,
		EIA_RESP_SLVERR = 2'b10
	} eia_resp_t;
endpackage : eia_pkg

// *** design/eia_aggregator.sv ***
// Extended interrupt aggregator with AXI4-Lite register access
//
// Contract
// - UART2 receive event, group A bit 1
// - UART4 transmit/receive, group A bits 2,3
// - UART2/UART4 baud overflow, group A bits 4,5
// - First energy pulse, group A bit 7
// - Interrupt 9: vector 4Bh, enable 1, flag 5
// - UART3 receive also sets interrupt 9 flag
// - UART5 transmit/receive, group B bits 2,3
// - UART5 baud overflow, group B bit 5
// - UART3 baud overflow feeds interrupt 9
// - Aux timer overflow/capture0, group D bits 0,1
// - Request needs global, own enable, enabled flag
// - Interrupt 8: vector 43h, enable 0, flag 4
// - Interrupt 11 flag bit 7, software set/clear
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "eia_params.svh"
module eia_aggregator
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] ev_group_a,
	input wire logic [7:0] ev_group_b,
	input wire logic [6:0] ev_group_d,
	input wire logic ev_uart3_tx,
	input wire logic ev_uart3_rx,
	input wire logic ev_uart3_ovf,
	output logic irq8_req,
	output logic irq9_req,
	output logic irq11_req,
	output logic [7:0] irq8_vector,
	output logic [7:0] irq9_vector,
	output logic [7:0] irq11_vector,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output eia_pkg::eia_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output eia_pkg::eia_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import eia_pkg::*;

	logic aw_hold_ff;
	logic w_hold_ff;
	logic [7:0] awaddr_ff;
	eia_reg_t wdata_ff;
	logic wstrb0_ff;
	logic bvalid_ff;
	eia_resp_t bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	eia_resp_t rresp_ff;
	eia_reg_t a_en_ff;
	eia_reg_t a_flags_ff;
	eia_reg_t b_en_ff;
	eia_reg_t b_flags_ff;
	eia_reg_t d_en_ff;
	eia_reg_t d_flags_ff;
	eia_reg_t core_en_ff;
	eia_reg_t ext_en_ff;
	eia_reg_t ext_flags_ff;
	eia_reg_t nxt_a_flags;
	eia_reg_t nxt_b_flags;
	eia_reg_t nxt_d_flags;
	eia_reg_t nxt_ext_flags;
	eia_reg_t ext_hw_set;
	eia_reg_t rd_val;
	logic rd_hit;
	logic wr_hit;
	logic do_write;
	logic do_read;
	logic wr_en;

	// Write address and data are caught independently; either may come first
	assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
	assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
	assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	// Registers are one byte wide, so only lane 0 carries anything
	assign wr_en = do_write & wstrb0_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Latch write address
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_hold_ff <= 1'b0;
			awaddr_ff <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end
		else if (do_write)
		begin
			aw_hold_ff <= 1'b0;
		end
	end

	// Latch write data
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			w_hold_ff <= 1'b0;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_ff <= 1'b1;
			wdata_ff <= s_axi_wdata[7:0];
			wstrb0_ff <= s_axi_wstrb[0];
		end
		else if (do_write)
		begin
			w_hold_ff <= 1'b0;
		end
	end

	// Write address decode
	always_comb
	begin
		unique case (awaddr_ff & 8'hfc)
			`EIA_OFS_A_EN, `EIA_OFS_A_FLAGS, `EIA_OFS_A_CLR,
			`EIA_OFS_B_EN, `EIA_OFS_B_FLAGS, `EIA_OFS_B_CLR,
			`EIA_OFS_D_EN, `EIA_OFS_D_FLAGS, `EIA_OFS_D_CLR,
			`EIA_OFS_CORE_EN, `EIA_OFS_EXT_EN, `EIA_OFS_EXT_FLAGS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Write response, held until the master takes it
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= EIA_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? EIA_RESP_OKAY : EIA_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			bvalid_ff <= 1'b0;
		end
	end

	// Enable registers; group flag registers themselves are read-only
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_en_ff <= `EIA_RST_REG;
			b_en_ff <= `EIA_RST_REG;
			d_en_ff <= `EIA_RST_REG;
			core_en_ff <= `EIA_RST_REG;
			ext_en_ff <= `EIA_RST_REG;
		end
		else if (wr_en)
		begin
			unique case (awaddr_ff & 8'hfc)
				`EIA_OFS_A_EN: a_en_ff <= wdata_ff & `EIA_MASK_A;
				`EIA_OFS_B_EN: b_en_ff <= wdata_ff & `EIA_MASK_B;
				`EIA_OFS_D_EN: d_en_ff <= wdata_ff & `EIA_MASK_D;
				`EIA_OFS_CORE_EN: core_en_ff <= wdata_ff & `EIA_MASK_CORE_EN;
				`EIA_OFS_EXT_EN: ext_en_ff <= wdata_ff & `EIA_MASK_EXT_EN;
				default: ;
			endcase
		end
	end

	// Sticky event flags: write-one-to-clear, a same-cycle event wins
	always_comb
	begin
		nxt_a_flags = a_flags_ff;
		nxt_b_flags = b_flags_ff;
		nxt_d_flags = d_flags_ff;
		if (wr_en && (awaddr_ff & 8'hfc) == `EIA_OFS_A_CLR)
		begin
			nxt_a_flags = a_flags_ff & ~wdata_ff;
		end
		if (wr_en && (awaddr_ff & 8'hfc) == `EIA_OFS_B_CLR)
		begin
			nxt_b_flags = b_flags_ff & ~wdata_ff;
		end
		if (wr_en && (awaddr_ff & 8'hfc) == `EIA_OFS_D_CLR)
		begin
			nxt_d_flags = d_flags_ff & ~wdata_ff;
		end
		nxt_a_flags = (nxt_a_flags | ev_group_a) & `EIA_MASK_A;
		nxt_b_flags = (nxt_b_flags | ev_group_b) & `EIA_MASK_B;
		nxt_d_flags = (nxt_d_flags | {1'b0, ev_group_d}) & `EIA_MASK_D;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_flags_ff <= `EIA_RST_REG;
			b_flags_ff <= `EIA_RST_REG;
			d_flags_ff <= `EIA_RST_REG;
		end
		else
		begin
			a_flags_ff <= nxt_a_flags;
			b_flags_ff <= nxt_b_flags;
			d_flags_ff <= nxt_d_flags;
		end
	end

	// Aggregate flags re-set while an enabled event flag stays set, which is why
	// software must drop the event flag before the aggregate one
	always_comb
	begin
		ext_hw_set = 8'h00;
		ext_hw_set[`EIA_BIT_FLAG_IRQ8] = |(a_en_ff & a_flags_ff);
		ext_hw_set[`EIA_BIT_FLAG_IRQ9] = |(b_en_ff & b_flags_ff) |
			(ext_en_ff[`EIA_BIT_EN_IRQ9] & (ev_uart3_tx | ev_uart3_rx | ev_uart3_ovf));
		ext_hw_set[`EIA_BIT_FLAG_IRQ11] = |(d_en_ff & d_flags_ff);
		nxt_ext_flags = ext_flags_ff;
		if (wr_en && (awaddr_ff & 8'hfc) == `EIA_OFS_EXT_FLAGS)
		begin
			nxt_ext_flags = wdata_ff;
		end
		nxt_ext_flags = (nxt_ext_flags | ext_hw_set) & `EIA_MASK_EXT_FLAGS;
	end

	// Aggregate flag storage
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_flags_ff <= `EIA_RST_REG;
		end
		else
		begin
			ext_flags_ff <= nxt_ext_flags;
		end
	end

	assign irq8_req = core_en_ff[`EIA_BIT_GLOBAL_EN] & ext_en_ff[`EIA_BIT_EN_IRQ8] &
		ext_flags_ff[`EIA_BIT_FLAG_IRQ8];
	assign irq9_req = core_en_ff[`EIA_BIT_GLOBAL_EN] & ext_en_ff[`EIA_BIT_EN_IRQ9] &
		ext_flags_ff[`EIA_BIT_FLAG_IRQ9];
	assign irq11_req = core_en_ff[`EIA_BIT_GLOBAL_EN] & ext_en_ff[`EIA_BIT_EN_IRQ11] &
		ext_flags_ff[`EIA_BIT_FLAG_IRQ11];
	assign irq = irq8_req | irq9_req | irq11_req;
	assign irq8_vector = `EIA_VECTOR_IRQ8;
	assign irq9_vector = `EIA_VECTOR_IRQ9;
	assign irq11_vector = `EIA_VECTOR_IRQ11;

	// Read decode; clear registers are write-only and read zero
	always_comb
	begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		unique case (s_axi_araddr & 8'hfc)
			`EIA_OFS_A_EN: rd_val = a_en_ff;
			`EIA_OFS_A_FLAGS: rd_val = a_flags_ff;
			`EIA_OFS_B_EN: rd_val = b_en_ff;
			`EIA_OFS_B_FLAGS: rd_val = b_flags_ff;
			`EIA_OFS_D_EN: rd_val = d_en_ff;
			`EIA_OFS_D_FLAGS: rd_val = d_flags_ff;
			`EIA_OFS_CORE_EN: rd_val = core_en_ff;
			`EIA_OFS_EXT_EN: rd_val = ext_en_ff | `EIA_ONES_EXT_EN;
			`EIA_OFS_EXT_FLAGS: rd_val = ext_flags_ff | `EIA_ONES_EXT_FLAGS;
			`EIA_OFS_A_CLR, `EIA_OFS_B_CLR, `EIA_OFS_D_CLR: rd_val = 8'h00;
			default: rd_hit = 1'b0;
		endcase
	end

	// Read channel, one outstanding read
	assign s_axi_arready = ~rvalid_ff;
	assign do_read = s_axi_arvalid & ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= EIA_RESP_OKAY;
		end
		else if (do_read)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_val};
			rresp_ff <= rd_hit ? EIA_RESP_OKAY : EIA_RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule : eia_aggregator

// *** verification/eia_aggregator_props.sv ***
// Port checker for the extended interrupt aggregator
`timescale 1ns/1ps
module eia_aggregator_props
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic irq8_req,
	input wire logic irq9_req,
	input wire logic irq11_req,
	input wire logic [7:0] irq8_vector,
	input wire logic [7:0] irq9_vector,
	input wire logic [7:0] irq11_vector,
	input wire logic irq,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import eia_pkg::*;
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_irq_any:
		assert property (irq == (irq8_req | irq9_req | irq11_req)) else $error("irq not OR of requests");
	a_vec_int8:
		assert property (irq8_vector == 8'h43) else $error("vector 8 wrong");
	a_vec_int9:
		assert property (irq9_vector == 8'h4b) else $error("vector 9 wrong");
	a_vec_int11:
		assert property (irq11_vector == 8'h5b) else $error("vector 11 wrong");
	// Outside reset, a request only drops through a software write
	a_irq_drop_write:
		assert property ($fell(irq) |-> s_axi_bvalid) else $error("irq fell without a write");
	a_ar_refused:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken during read answer");
	a_aw_refused:
		assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken during write answer");
	a_read_answer:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_read_done:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	a_write_done:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_rdata_upper:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule : eia_aggregator_props
bind eia_aggregator eia_aggregator_props u_props (.mclk, .rst_n, .irq8_req, .irq9_req, .irq11_req, .irq8_vector,
	.irq9_vector, .irq11_vector, .irq, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// *** verification/eia_core_model.sv ***
// Core model taking the vector of the most urgent pending request
`timescale 1ns/1ps
module eia_core_model
(
	input wire logic irq,
	input wire logic irq8_req,
	input wire logic irq9_req,
	input wire logic [7:0] irq8_vector,
	input wire logic [7:0] irq9_vector,
	input wire logic [7:0] irq11_vector,
	output logic [7:0] vector_taken
);
	// polling order 8, 9, 11; zero while idle
	always_comb
	begin
		if (!irq)
			vector_taken = 8'h00;
		else if (irq8_req)
			vector_taken = irq8_vector;
		else if (irq9_req)
			vector_taken = irq9_vector;
		else
			vector_taken = irq11_vector;
	end
endmodule : eia_core_model

// *** verification/eia_aggregator_bench.sv ***
// Self-checking bench of the extended interrupt aggregator
`timescale 1ns/1ps
module eia_aggregator_bench;
	import eia_pkg::*;
	typedef struct {logic [1:0] grp; int b; logic [2:0] irqs;} eia_row_t;
	logic mclk = 0, rst_n = 0, ev_uart3_tx = 0, ev_uart3_rx = 0, ev_uart3_ovf = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] ev_group_a = '0, ev_group_b = '0, s_axi_awaddr = '0, s_axi_araddr = '0, ea, vector_taken;
	logic [6:0] ev_group_d = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, fb;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic irq8_req, irq9_req, irq11_req, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] irq8_vector, irq9_vector, irq11_vector;
	eia_resp_t s_axi_bresp, s_axi_rresp;
	int num_errors = 0, tests_run = 0;
	// Group (a, b, d, uart3), bit, expected requests {11, 9, 8}
	eia_row_t rows [14] = '{'{0, 1, 1}, '{0, 2, 1}, '{0, 3, 1}, '{0, 4, 1}, '{0, 5, 1}, '{0, 7, 1}, '{1, 2, 2},
		'{1, 3, 2}, '{1, 5, 2}, '{2, 0, 4}, '{2, 1, 4}, '{3, 0, 2}, '{3, 1, 2}, '{3, 2, 2}};
	always #2.5 mclk = ~mclk;
	eia_aggregator uut (.mclk, .rst_n, .ev_group_a, .ev_group_b, .ev_group_d, .ev_uart3_tx, .ev_uart3_rx,
		.ev_uart3_ovf, .irq8_req, .irq9_req, .irq11_req, .irq8_vector, .irq9_vector, .irq11_vector, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	eia_core_model core (.irq, .irq8_req, .irq9_req, .irq8_vector, .irq9_vector, .irq11_vector, .vector_taken);
	task give_verdict;
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask : chk
	// A spent bound means a hang: count it and stop
	task guard(input int n);
		if (n >= 50)
		begin
			num_errors++;
			give_verdict();
		end
	endtask : guard
	task wr(input logic [7:0] a, input logic [7:0] d, input eia_resp_t er = EIA_RESP_OKAY);
		logic ta, tw, tb;
		eia_resp_t r;
		int n;
		ta = 0;
		tw = 0;
		tb = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		// Ready is sampled mid-cycle, where it is settled, and acted on at the edge
		for (n = 0; n < 50 && !(ta && tw); n++)
		begin
			@(negedge mclk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge mclk);
			if (ta)
				s_axi_awvalid <= 0;
			if (tw)
				s_axi_wvalid <= 0;
		end
		guard(n);
		for (n = 0; n < 50 && !tb; n++)
		begin
			@(negedge mclk);
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge mclk);
		end
		guard(n);
		s_axi_bready <= 0;
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp, input eia_resp_t er = EIA_RESP_OKAY);
		logic ta, tb;
		logic [31:0] d;
		eia_resp_t r;
		int n;
		ta = 0;
		tb = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 50 && !ta; n++)
		begin
			@(negedge mclk);
			ta = s_axi_arready;
			@(posedge mclk);
		end
		s_axi_arvalid <= 0;
		for (n = n; n < 50 && !tb; n++)
		begin
			@(negedge mclk);
			tb = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
		end
		guard(n);
		s_axi_rready <= 0;
		chk("rdata", exp, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd
	// One-cycle event, then room for flag, aggregate and request
	task pulse(input eia_row_t r);
		@(posedge mclk);
		case (r.grp)
			2'd0: ev_group_a <= 8'h01 << r.b;
			2'd1: ev_group_b <= 8'h01 << r.b;
			2'd2: ev_group_d <= 7'h01 << r.b;
			default: {ev_uart3_ovf, ev_uart3_rx, ev_uart3_tx} <= 3'h1 << r.b;
		endcase
		@(posedge mclk);
		{ev_group_a, ev_group_b, ev_group_d, ev_uart3_ovf, ev_uart3_rx, ev_uart3_tx} <= '0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask : pulse
	initial
	begin
		repeat (12) @(posedge mclk);
		rst_n <= 1;
		rd(8'h28, 32'he0);
		rd(8'h2c, 32'h08);
		rd(8'h04, 32'h00);
		wr(8'h24, 8'h80);
		wr(8'h28, 8'h0b);
		// Each routed event: request, vector, then for groups a, b, d the event flag checked and cleared before aggregate
		foreach (rows[i])
		begin
			ea = 8'(rows[i].grp * 12);
			fb = rows[i].irqs == 3'd1 ? 32'h10 : rows[i].irqs == 3'd2 ? 32'h20 : 32'h80;
			if (rows[i].grp != 2'd3)
				wr(ea, 8'h01 << rows[i].b);
			pulse(rows[i]);
			chk("req", {29'h0, rows[i].irqs}, {29'h0, irq11_req, irq9_req, irq8_req});
			chk("vector", fb == 32'h10 ? 32'h43 : fb == 32'h20 ? 32'h4b : 32'h5b, {24'h0, vector_taken});
			if (rows[i].grp != 2'd3)
			begin
				rd(ea + 8'h04, 32'h1 << rows[i].b);
				wr(ea + 8'h08, 8'h01 << rows[i].b);
				wr(ea, 8'h00);
			end
			rd(8'h2c, 32'h08 | fb);
			wr(8'h2c, 8'h00);
			@(negedge mclk);
			chk("irq", 32'h0, {31'h0, irq});
		end
		// Reserved group A bit neither stores an enable nor flags
		wr(8'h00, 8'hff);
		rd(8'h00, 32'hbf);
		pulse('{0, 6, 0});
		rd(8'h04, 32'h00);
		wr(8'h00, 8'h02);
		// Clearing the aggregate first is undone while the event flag stands
		pulse('{0, 1, 1});
		wr(8'h2c, 8'h00);
		rd(8'h2c, 32'h18);
		rd(8'h04, 32'h02);
		wr(8'h08, 8'h02);
		wr(8'h2c, 8'h00);
		rd(8'h2c, 32'h08);
		wr(8'h00, 8'h00);
		// Software-set interrupt 11 flag waits for the global enable
		wr(8'h24, 8'h00);
		wr(8'h2c, 8'h80);
		@(negedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'h24, 8'h80);
		@(negedge mclk);
		chk("irq11", 32'h1, {31'h0, irq11_req});
		// Mid-run reset must drop the pending request, the global enable and the aggregate flags
		@(posedge mclk);
		rst_n <= 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1;
		@(negedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		rd(8'h24, 32'h00);
		rd(8'h2c, 32'h08);
		wr(8'h2c, 8'h00);
		// Unmapped offset is refused both ways
		wr(8'h30, 8'h5a, EIA_RESP_SLVERR);
		rd(8'h30, 32'h0, EIA_RESP_SLVERR);
		give_verdict();
	end
endmodule : eia_aggregator_bench
